// [src/itrb_image_tuning.v]
// Image tuning register bank with serial access and pixel-side control logic
`timescale 1ns/1ns
module itrb_image_tuning #(
    parameter MONO = 0,
    parameter AVG_SHIFT = 17,
    parameter CNT_W = 20
) (
    // Clock and reset
    input wire mclk_i,
    input wire rst_b_i,
    // Serial control pins
    input wire sccb_clk_i,
    input wire sccb_data_i,
    output reg sccb_data_o,
    output reg sccb_data_oe_o,
    // Control bits held outside this bank
    input wire offset_adj_en_i,
    input wire offset_src_host_i,
    input wire [1:0] ap_threshold_i,
    input wire [1:0] ap_strength_i,
    input wire [1:0] wb_luma_lo_i,
    input wire [1:0] wb_luma_hi_i,
    input wire wb_enable_i,
    input wire wb_rate_long_i,
    input wire [7:0] dark_pixel_ratio_limit_i,
    input wire interlaced_i,
    input wire qres_one_line_i,
    // Internal offset calibration
    input wire int_offset_valid_i,
    input wire [7:0] int_luma_offset_i,
    input wire [7:0] int_chroma_u_offset_i,
    // Status from white balance engine
    input wire wb_stable_i,
    // Pixel stream in
    input wire [7:0] pix_i,
    input wire pix_valid_i,
    input wire [1:0] pix_chan_i,
    input wire frame_start_i,
    input wire line_end_i,
    // Pixel stream out
    output reg [7:0] pix_o,
    output reg pix_valid_o,
    // Measurements and control out
    output reg [7:0] luminance_average_o,
    output reg [CNT_W-1:0] wb_pix_count_o,
    output reg wb_update_o,
    output reg wb_fast_o,
    output reg wb_manual_en_o,
    output reg ae_stable_o,
    output reg ae_brighten_o,
    output reg ae_darken_o,
    output reg ob_update_en_o,
    output reg qres_clk_opt_o,
    output reg [1:0] xtal_power_o,
    output reg adc_half_current_o,
    output reg drive_boost_o
);
    `include "itrb_regs.vh"

    // ==========================================================
    // Register storage
    reg [7:0] ipc_q;
    reg [7:0] luma_offset_adjust_q;
    reg [7:0] chroma_u_offset_adjust_q;
    reg [7:0] oam_q;
    reg [7:0] aew_q;
    reg reg_wr;
    reg [7:0] reg_addr_q;
    reg [7:0] reg_wdata;
    reg [7:0] rd_data;

    // ==========================================================
    // Serial pin synchronisers
    reg scl_s1_q;
    reg scl_s2_q;
    reg scl_d_q;
    reg sda_s1_q;
    reg sda_s2_q;
    reg sda_d_q;
    wire scl_rise = scl_s2_q & ~scl_d_q;
    wire scl_fall = ~scl_s2_q & scl_d_q;
    wire bus_start = scl_s2_q & scl_d_q & sda_d_q & ~sda_s2_q;
    wire bus_stop = scl_s2_q & scl_d_q & ~sda_d_q & sda_s2_q;

    always @(posedge mclk_i) begin
        if (!rst_b_i) begin
            scl_s1_q <= 1'b1;
            scl_s2_q <= 1'b1;
            scl_d_q <= 1'b1;
            sda_s1_q <= 1'b1;
            sda_s2_q <= 1'b1;
            sda_d_q <= 1'b1;
        end else begin
            scl_s1_q <= sccb_clk_i;
            scl_s2_q <= scl_s1_q;
            scl_d_q <= scl_s2_q;
            sda_s1_q <= sccb_data_i;
            sda_s2_q <= sda_s1_q;
            sda_d_q <= sda_s2_q;
        end
    end

    // ==========================================================
    // Serial phase machine
    localparam [4:0] ST_IDLE = 5'h01;
    localparam [4:0] ST_ID = 5'h02;
    localparam [4:0] ST_ADDR = 5'h04;
    localparam [4:0] ST_WDATA = 5'h08;
    localparam [4:0] ST_RDATA = 5'h10;

    reg [4:0] st_q;
    reg [3:0] bit_q;
    reg [7:0] shift_q;
    reg [7:0] tx_q;
    wire [7:0] shift_nx = {shift_q[6:0], sda_s2_q};

    // Read mux
    always @* begin
        case (reg_addr_q)
            `ITRB_OFF_IMAGE_PROC_CONTROL: rd_data = ipc_q;
            `ITRB_OFF_LUMA_OFFSET_ADJUST: rd_data = luma_offset_adjust_q;
            `ITRB_OFF_CHROMA_U_OFFSET_ADJUST: rd_data = chroma_u_offset_adjust_q;
            `ITRB_OFF_OSC_ADC_MISC_CONTROL: rd_data = oam_q;
            `ITRB_OFF_BRIGHT_PIXEL_RATIO_LIMIT: rd_data = aew_q;
            default: rd_data = 8'h00;
        endcase
    end

    always @(posedge mclk_i) begin
        if (!rst_b_i) begin
            st_q <= ST_IDLE;
            bit_q <= 4'h0;
            shift_q <= 8'h00;
            tx_q <= 8'h00;
            reg_addr_q <= 8'h00;
            reg_wr <= 1'b0;
            reg_wdata <= 8'h00;
            sccb_data_o <= 1'b0;
            sccb_data_oe_o <= 1'b0;
        end else begin
            reg_wr <= 1'b0;
            if (bus_start) begin
                st_q <= ST_ID;
                bit_q <= 4'h0;
                sccb_data_oe_o <= 1'b0;
            end else if (bus_stop) begin
                st_q <= ST_IDLE;
                sccb_data_oe_o <= 1'b0;
            end else if (scl_rise && st_q != ST_IDLE) begin
                if (bit_q == 4'h8) begin
                    bit_q <= 4'h0;
                    case (st_q)
                        ST_ID: begin
                            if (shift_q[7:1] != `ITRB_SCCB_DEV_ID) begin
                                st_q <= ST_IDLE;
                            end else if (shift_q[0]) begin
                                st_q <= ST_RDATA;
                                tx_q <= rd_data;
                            end else begin
                                st_q <= ST_ADDR;
                            end
                        end
                        ST_ADDR: begin
                            reg_addr_q <= shift_q;
                            st_q <= ST_WDATA;
                        end
                        ST_WDATA: begin
                            reg_wr <= 1'b1;
                            reg_wdata <= shift_q;
                            st_q <= ST_IDLE;
                        end
                        ST_RDATA: st_q <= ST_IDLE;
                        default: st_q <= ST_IDLE;
                    endcase
                end else begin
                    bit_q <= bit_q + 4'h1;
                    shift_q <= shift_nx;
                end
            end else if (scl_fall) begin
                // Drive only during the eight read bits; the ninth is released
                if (st_q == ST_RDATA && bit_q != 4'h8) begin
                    sccb_data_oe_o <= 1'b1;
                    sccb_data_o <= tx_q[3'h7 - bit_q[2:0]];
                end else begin
                    sccb_data_oe_o <= 1'b0;
                end
            end
        end
    end

    // ==========================================================
    // Register writes and internal offset updates
    wire wr_ipc = reg_wr && reg_addr_q == `ITRB_OFF_IMAGE_PROC_CONTROL;
    wire wr_luma_offset_adjust = reg_wr && reg_addr_q == `ITRB_OFF_LUMA_OFFSET_ADJUST;
    wire wr_chroma_u_offset_adjust = reg_wr && reg_addr_q == `ITRB_OFF_CHROMA_U_OFFSET_ADJUST;
    wire wr_oam = reg_wr && reg_addr_q == `ITRB_OFF_OSC_ADC_MISC_CONTROL;
    wire wr_aew = reg_wr && reg_addr_q == `ITRB_OFF_BRIGHT_PIXEL_RATIO_LIMIT;
    // Monochrome parts hold the WB smart and always-fast bits at zero
    wire [7:0] ipc_mask = (MONO != 0) ? 8'hF5 : 8'hFF;

    always @(posedge mclk_i) begin
        if (!rst_b_i) begin
            ipc_q <= `ITRB_RST_IMAGE_PROC_CONTROL;
            luma_offset_adjust_q <= `ITRB_RST_LUMA_OFFSET_ADJUST;
            chroma_u_offset_adjust_q <= `ITRB_RST_CHROMA_U_OFFSET_ADJUST;
            oam_q <= `ITRB_RST_OSC_ADC_MISC_CONTROL;
            aew_q <= `ITRB_RST_BRIGHT_PIXEL_RATIO_LIMIT;
        end else begin
            if (wr_ipc) begin
                ipc_q <= reg_wdata & ipc_mask;
            end
            if (wr_oam) begin
                oam_q <= reg_wdata;
            end
            if (wr_aew) begin
                aew_q <= reg_wdata;
            end
            if (!offset_src_host_i) begin
                // Host writes dropped; calibration owns the value
                if (int_offset_valid_i) begin
                    luma_offset_adjust_q <= int_luma_offset_i;
                    chroma_u_offset_adjust_q <= int_chroma_u_offset_i;
                end
            end else begin
                if (wr_luma_offset_adjust) begin
                    luma_offset_adjust_q <= reg_wdata;
                end
                if (wr_chroma_u_offset_adjust) begin
                    chroma_u_offset_adjust_q <= reg_wdata;
                end
            end
        end
    end

    // ==========================================================
    // Aperture correction on the luma / green channel
    reg [7:0] prev_luma_q;
    reg [7:0] ap_pix;
    reg [7:0] ap_thr;
    reg [10:0] ap_adj;
    wire is_luma = pix_chan_i == 2'b00;
    wire [8:0] ap_diff = {1'b0, pix_i} - {1'b0, prev_luma_q};
    wire [8:0] ap_abs = ap_diff[8] ? (9'h000 - ap_diff) : ap_diff;

    always @* begin
        case (ap_threshold_i)
            2'b00: ap_thr = 8'h03;
            2'b01: ap_thr = 8'h06;
            2'b10: ap_thr = 8'h0A;
            default: ap_thr = 8'h10;
        endcase
        // Strength steps 0, 50, 100, 200 percent of the neighbour difference
        case (ap_strength_i)
            2'b00: ap_adj = 11'h000;
            2'b01: ap_adj = {{3{ap_diff[8]}}, ap_diff[8:1]};
            2'b10: ap_adj = {{2{ap_diff[8]}}, ap_diff};
            default: ap_adj = {ap_diff[8], ap_diff, 1'b0};
        endcase
        ap_pix = pix_i;
        if (ipc_q[`ITRB_IPC_APERTURE_EN] && is_luma && ap_abs > {1'b0, ap_thr}) begin
            if ($signed({3'b000, pix_i}) + $signed(ap_adj) > $signed(11'h0FF)) begin
                ap_pix = 8'hFF;
            end else if ($signed({3'b000, pix_i}) + $signed(ap_adj) < $signed(11'h000)) begin
                ap_pix = 8'h00;
            end else begin
                ap_pix = pix_i + ap_adj[7:0];
            end
        end
    end

    // ==========================================================
    // Channel offset selection and application
    // Same channel codes serve YUV and raw: green rides Y, blue rides U
    wire [7:0] ofs_sel = (pix_chan_i == 2'b00) ? luma_offset_adjust_q : chroma_u_offset_adjust_q;
    wire ofs_en = offset_adj_en_i && pix_chan_i != 2'b10;
    wire [7:0] ofs_pix;

    itrb_offset_apply u_ofs (
        .pix_i(ap_pix),
        .offset_i(ofs_sel),
        .enable_i(ofs_en),
        .pix_o(ofs_pix)
    );

    // ==========================================================
    // Quarter-resolution line gating
    reg line_odd_q;
    wire two_line = qres_one_line_i && oam_q[`ITRB_OAM_QRES_TWO_LINE];

    always @(posedge mclk_i) begin
        if (!rst_b_i) begin
            line_odd_q <= 1'b0;
            pix_o <= 8'h00;
            pix_valid_o <= 1'b0;
            prev_luma_q <= 8'h00;
            qres_clk_opt_o <= 1'b0;
        end else begin
            if (frame_start_i) begin
                line_odd_q <= 1'b0;
            end else if (line_end_i) begin
                line_odd_q <= ~line_odd_q;
            end
            if (pix_valid_i && is_luma) begin
                prev_luma_q <= pix_i;
            end
            pix_o <= ofs_pix;
            pix_valid_o <= pix_valid_i && !(two_line && line_odd_q);
            qres_clk_opt_o <= qres_one_line_i && oam_q[`ITRB_OAM_QRES_CLK_OPT];
        end
    end

    // ==========================================================
    // Per-field statistics
    reg [CNT_W+7:0] luma_sum_q;
    reg [CNT_W-1:0] total_q;
    reg [CNT_W-1:0] bright_q;
    reg [CNT_W-1:0] dark_q;
    reg [CNT_W-1:0] wb_cnt_q;
    wire luma_pix = pix_valid_i && is_luma;
    wire [7:0] wb_lo = {wb_luma_lo_i, 6'h00};
    wire [7:0] wb_hi = {wb_luma_hi_i, 6'h3F};
    wire wb_in_range = pix_i >= wb_lo && pix_i <= wb_hi;
    wire wb_count = !ipc_q[`ITRB_IPC_WB_SMART] || wb_in_range;
    wire [3:0] step = interlaced_i ? `ITRB_STEP_INTERLACED : `ITRB_STEP_PROGRESSIVE;
    wire [CNT_W+13:0] bright_scaled = bright_q * `ITRB_STEP_SCALE;
    wire [CNT_W+13:0] dark_scaled = dark_q * `ITRB_STEP_SCALE;
    wire [CNT_W+13:0] bright_lim = aew_q * step * total_q;
    wire [CNT_W+13:0] dark_lim = dark_pixel_ratio_limit_i * step * total_q;
    wire [CNT_W+7:0] avg_full = luma_sum_q >> AVG_SHIFT;

    always @(posedge mclk_i) begin
        if (!rst_b_i) begin
            luma_sum_q <= {(CNT_W+8){1'b0}};
            total_q <= {CNT_W{1'b0}};
            bright_q <= {CNT_W{1'b0}};
            dark_q <= {CNT_W{1'b0}};
            wb_cnt_q <= {CNT_W{1'b0}};
            luminance_average_o <= 8'h00;
            wb_pix_count_o <= {CNT_W{1'b0}};
            ae_stable_o <= 1'b0;
            ae_brighten_o <= 1'b0;
            ae_darken_o <= 1'b0;
        end else if (frame_start_i) begin
            if (ipc_q[`ITRB_IPC_LUMA_AVG_EN]) begin
                luminance_average_o <= (avg_full > 255) ? 8'hFF : avg_full[7:0];
            end
            wb_pix_count_o <= wb_cnt_q;
            // Too many bright pixels darkens; a larger limit tolerates more
            ae_darken_o <= bright_scaled > bright_lim;
            ae_brighten_o <= dark_scaled > dark_lim;
            ae_stable_o <= bright_scaled <= bright_lim && dark_scaled <= dark_lim;
            luma_sum_q <= {(CNT_W+8){1'b0}};
            total_q <= {CNT_W{1'b0}};
            bright_q <= {CNT_W{1'b0}};
            dark_q <= {CNT_W{1'b0}};
            wb_cnt_q <= {CNT_W{1'b0}};
        end else if (luma_pix) begin
            luma_sum_q <= luma_sum_q + {{CNT_W{1'b0}}, pix_i};
            total_q <= total_q + 1'b1;
            if (pix_i > `ITRB_BRIGHT_LEVEL) begin
                bright_q <= bright_q + 1'b1;
            end
            if (pix_i < `ITRB_DARK_LEVEL) begin
                dark_q <= dark_q + 1'b1;
            end
            if (wb_count) begin
                wb_cnt_q <= wb_cnt_q + 1'b1;
            end
        end
    end

    // ==========================================================
    // White balance update pacing
    localparam [2:0] WB_OFF = 3'h1;
    localparam [2:0] WB_FAST = 3'h2;
    localparam [2:0] WB_SLOW = 3'h4;

    reg [2:0] wb_st_q;
    reg [5:0] wb_fld_q;
    wire always_fast = ipc_q[`ITRB_IPC_WB_ALWAYS_FAST];
    wire [5:0] slow_last = wb_rate_long_i ? `ITRB_WB_SLOW_LONG : `ITRB_WB_SLOW_SHORT;

    always @(posedge mclk_i) begin
        if (!rst_b_i) begin
            wb_st_q <= WB_OFF;
            wb_fld_q <= 6'h00;
            wb_update_o <= 1'b0;
            wb_fast_o <= 1'b0;
            wb_manual_en_o <= 1'b0;
            ob_update_en_o <= 1'b0;
            xtal_power_o <= 2'b00;
            adc_half_current_o <= 1'b0;
            drive_boost_o <= 1'b0;
        end else begin
            wb_update_o <= 1'b0;
            wb_manual_en_o <= wb_enable_i && ipc_q[`ITRB_IPC_WB_MANUAL_IN_AUTO];
            ob_update_en_o <= oam_q[`ITRB_OAM_OB_UPDATE];
            xtal_power_o <= oam_q[`ITRB_OAM_XTAL_HI:`ITRB_OAM_XTAL_LO];
            adc_half_current_o <= oam_q[`ITRB_OAM_ADC_HALF];
            drive_boost_o <= ipc_q[`ITRB_IPC_DRIVE_BOOST];
            wb_fast_o <= wb_st_q == WB_FAST;
            if (!wb_enable_i) begin
                wb_st_q <= WB_OFF;
            end else if (frame_start_i) begin
                case (wb_st_q)
                    WB_OFF: begin
                        wb_st_q <= WB_FAST;
                    end
                    WB_FAST: begin
                        wb_update_o <= 1'b1;
                        wb_fld_q <= 6'h00;
                        if (!always_fast && wb_stable_i) begin
                            wb_st_q <= WB_SLOW;
                        end
                    end
                    WB_SLOW: begin
                        if (always_fast) begin
                            wb_st_q <= WB_FAST;
                        end else if (wb_fld_q >= slow_last) begin
                            wb_update_o <= 1'b1;
                            wb_fld_q <= 6'h00;
                        end else begin
                            wb_fld_q <= wb_fld_q + 6'h01;
                        end
                    end
                    default: wb_st_q <= WB_OFF;
                endcase
            end
        end
    end
endmodule // itrb_image_tuning

// [src/itrb_regs.vh]
// Register offsets, field positions, reset values and constants of the image tuning bank
`ifndef ITRB_REGS_VH
`define ITRB_REGS_VH

// ==========================================================
// Register offsets
`define ITRB_OFF_IMAGE_PROC_CONTROL 8'h20
`define ITRB_OFF_LUMA_OFFSET_ADJUST 8'h21
`define ITRB_OFF_CHROMA_U_OFFSET_ADJUST 8'h22
`define ITRB_OFF_OSC_ADC_MISC_CONTROL 8'h23
`define ITRB_OFF_BRIGHT_PIXEL_RATIO_LIMIT 8'h24

// ==========================================================
// Reset values
`define ITRB_RST_IMAGE_PROC_CONTROL 8'h80
`define ITRB_RST_LUMA_OFFSET_ADJUST 8'h00
`define ITRB_RST_CHROMA_U_OFFSET_ADJUST 8'h80
`define ITRB_RST_OSC_ADC_MISC_CONTROL 8'hDE
`define ITRB_RST_BRIGHT_PIXEL_RATIO_LIMIT 8'h30

// ==========================================================
// Image control word fields
`define ITRB_IPC_LUMA_AVG_EN 6
`define ITRB_IPC_APERTURE_EN 4
`define ITRB_IPC_WB_SMART 3
`define ITRB_IPC_WB_MANUAL_IN_AUTO 2
`define ITRB_IPC_WB_ALWAYS_FAST 1
`define ITRB_IPC_DRIVE_BOOST 0

// ==========================================================
// Offset register fields
`define ITRB_OFS_DIR 7

// ==========================================================
// Oscillator / misc control fields
`define ITRB_OAM_XTAL_HI 7
`define ITRB_OAM_XTAL_LO 6
`define ITRB_OAM_ADC_HALF 5
`define ITRB_OAM_OB_UPDATE 4
`define ITRB_OAM_QRES_CLK_OPT 1
`define ITRB_OAM_QRES_TWO_LINE 0

// ==========================================================
// Exposure ratio steps, in tenths of a percent per LSB
`define ITRB_STEP_INTERLACED 4'hD
`define ITRB_STEP_PROGRESSIVE 4'h7
`define ITRB_STEP_SCALE 10'h3E8
`define ITRB_BRIGHT_LEVEL 8'hC0
`define ITRB_DARK_LEVEL 8'h30

// ==========================================================
// Serial port and white balance slow-rate limits
`define ITRB_SCCB_DEV_ID 7'h2A
`define ITRB_WB_SLOW_SHORT 6'h0F
`define ITRB_WB_SLOW_LONG 6'h3F

`endif

// [src/itrb_offset_apply.v]
// Signed digital offset applied to one pixel channel, with clamping
`timescale 1ns/1ns
module itrb_offset_apply (
    // Pixel in
    input wire [7:0] pix_i,
    // Offset word: direction and magnitude
    input wire [7:0] offset_i,
    input wire enable_i,
    // Pixel out
    output reg [7:0] pix_o
);
    `include "itrb_regs.vh"

    reg [9:0] sum;

    // ==========================================================
    // Add or subtract, clamp to 0..255
    always @* begin
        sum = {2'b00, pix_i};
        if (enable_i) begin
            if (offset_i[`ITRB_OFS_DIR]) begin
                sum = {2'b00, pix_i} - {3'b000, offset_i[6:0]};
            end else begin
                sum = {2'b00, pix_i} + {3'b000, offset_i[6:0]};
            end
        end
        if (sum[9]) begin
            pix_o = 8'h00;
        end else if (sum[8]) begin
            pix_o = 8'hFF;
        end else begin
            pix_o = sum[7:0];
        end
    end
endmodule // itrb_offset_apply

// [verif/itrb_sccb_host.sv]
// Serial host model that programs and reads the bank over its two-wire pins
`timescale 1ns/1ns
`include "itrb_regs.vh"
module itrb_sccb_host (
    // Serial pins, data is open-drain
    input wire sda_i,
    output logic scl_o,
    output logic sda_low_o
);
    // ==========================================================
    // Framing
    // 3 mclk steps keep every pin change on a falling mclk edge
    localparam int Q = 24;
    initial begin
        scl_o = 1'b1;
        sda_low_o = 1'b0;
    end
    task automatic frame_edge(input logic stop);
        #Q sda_low_o = stop;
        #Q scl_o = 1'b1;
        #Q sda_low_o = !stop;
        if (!stop) #Q scl_o = 1'b0;
    endtask
    // Ninth bit released: the bank ignores it
    task automatic byte_io(input logic [7:0] b, output logic [7:0] got);
        for (int i = 8; i >= 0; i--) begin
            #Q sda_low_o = (i > 0) ? !b[i-1] : 1'b0;
            #Q scl_o = 1'b1;
            if (i > 0) got[i-1] = sda_i;
            #(2*Q) scl_o = 1'b0;
        end
    endtask
    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] x;
        frame_edge(1'b0);
        byte_io({`ITRB_SCCB_DEV_ID, 1'b0}, x);
        byte_io(a, x);
        byte_io(d, x);
        frame_edge(1'b1);
    endtask
    task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
        logic [7:0] x;
        frame_edge(1'b0);
        byte_io({`ITRB_SCCB_DEV_ID, 1'b0}, x);
        byte_io(a, x);
        frame_edge(1'b1);
        frame_edge(1'b0);
        byte_io({`ITRB_SCCB_DEV_ID, 1'b1}, x);
        byte_io(8'hFF, d);
        frame_edge(1'b1);
    endtask
endmodule // itrb_sccb_host

// [verif/itrb_image_tuning_checker.sv]
// Port-level assertions for the image tuning register bank
`timescale 1ns/1ns
module itrb_image_tuning_checker (
    // Clock, reset and watched inputs
    input wire mclk_i,
    input wire rst_b_i,
    input wire offset_adj_en_i,
    input wire wb_enable_i,
    input wire qres_one_line_i,
    input wire frame_start_i,
    input wire pix_valid_i,
    input wire [1:0] pix_chan_i,
    input wire [7:0] pix_i,
    // Watched outputs
    input wire [7:0] pix_o,
    input wire pix_valid_o,
    input wire wb_update_o,
    input wire wb_fast_o,
    input wire wb_manual_en_o,
    input wire ae_darken_o,
    input wire qres_clk_opt_o
);
    // ==========================================================
    // Properties
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_b_i);
    a_offset_bypass: assert property ($past(rst_b_i) && pix_valid_i && !offset_adj_en_i
        |=> pix_o == $past(pix_i)) else $error("pixel altered with offsets off");
    a_red_plain: assert property ($past(rst_b_i) && pix_valid_i && pix_chan_i == 2'h2
        |=> pix_o == $past(pix_i)) else $error("red pixel altered");
    a_valid_follow: assert property ($past(rst_b_i) && !qres_one_line_i
        |=> pix_valid_o == $past(pix_valid_i)) else $error("pixel valid lost");
    a_update_field: assert property (wb_update_o
        |-> $past(frame_start_i)) else $error("gain update off field start");
    a_wb_off_idle: assert property (!wb_enable_i [*2]
        |=> !wb_fast_o) else $error("fast state while balance off");
    a_manual_gate: assert property (wb_manual_en_o
        |-> $past(wb_enable_i)) else $error("manual gains without auto balance");
    a_qres_gate: assert property (qres_clk_opt_o
        |-> $past(qres_one_line_i)) else $error("clock option outside one-line mode");
    a_ae_field: assert property ($changed(ae_darken_o)
        |-> $past(frame_start_i)) else $error("exposure verdict off field start");
    c_wb_update: cover property (wb_update_o);
    c_offset_pix: cover property (pix_valid_i && offset_adj_en_i && pix_chan_i == 2'h1);
    c_darken: cover property ($rose(ae_darken_o));
endmodule // itrb_image_tuning_checker

// [verif/itrb_image_tuning_tb.sv]
// Self-checking bench for the image tuning register bank
`timescale 1ns/1ns
module itrb_image_tuning_tb;
    // ==========================================================
    // Signals
    logic mclk_i = 1'b0, rst_b_i = 1'b0, offset_adj_en_i = 1'b0, offset_src_host_i = 1'b0;
    logic wb_enable_i = 1'b0, wb_rate_long_i = 1'b0, qres_one_line_i = 1'b0, wb_stable_i = 1'b0;
    logic int_offset_valid_i = 1'b0, pix_valid_i = 1'b0, frame_start_i = 1'b0, line_end_i = 1'b0;
    logic interlaced_i;
    logic [1:0] ap_threshold_i, ap_strength_i, wb_luma_lo_i, wb_luma_hi_i, pix_chan_i = 2'h0, ch;
    logic [7:0] dark_pixel_ratio_limit_i = 8'h9A;
    logic [7:0] int_luma_offset_i = 8'h00, int_chroma_u_offset_i = 8'h00, pix_i = 8'h00;
    wire sccb_clk_i, sccb_data_i, sccb_data_o, sccb_data_oe_o, host_low, pix_valid_o, wb_update_o;
    wire wb_fast_o, wb_manual_en_o, ae_stable_o, ae_brighten_o, ae_darken_o, ob_update_en_o;
    wire qres_clk_opt_o, adc_half_current_o, drive_boost_o;
    wire [7:0] pix_o, luminance_average_o;
    wire [1:0] xtal_power_o;
    wire [19:0] wb_pix_count_o;
    int fails = 0, check_count = 0, upd = 0;
    logic [31:0] seed = 32'hB4F3, r, lim;
    logic [7:0] exp_q[$], rd, bright_pixel_ratio_limit;
    logic [7:0] rst_tab[6] = '{8'h80, 8'h00, 8'h80, 8'hDE, 8'h30, 8'h00};
    // Pull-up: a released line reads high
    assign sccb_data_i = !(host_low || (sccb_data_oe_o && !sccb_data_o));
    itrb_image_tuning dut_u (.*);
    itrb_sccb_host host_u (.sda_i(sccb_data_i), .scl_o(sccb_clk_i), .sda_low_o(host_low));
    initial begin
        forever #4 mclk_i = ~mclk_i;
    end
    // ==========================================================
    // Helpers
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
        host_u.reg_read(a, rd);
        check($sformatf("reg_%h", a), rd, e);
    endtask
    // Expected pixel noted at drive time, clamped to 00..FF
    task automatic pix(input logic [1:0] c, input logic [7:0] p, input logic [7:0] o);
        logic [8:0] s;
        s = o[7] ? {1'b0, p} - {2'b00, o[6:0]} : {1'b0, p} + {2'b00, o[6:0]};
        if (!offset_adj_en_i || c == 2'h2) s = {1'b0, p};
        else if (s[8]) s = o[7] ? 9'h000 : 9'h0FF;
        @(negedge mclk_i);
        pix_chan_i = c;
        pix_i = p;
        pix_valid_i = 1'b1;
        exp_q.push_back(s[7:0]);
    endtask
    task automatic frame();
        @(negedge mclk_i) frame_start_i = 1'b1;
        @(negedge mclk_i) frame_start_i = 1'b0;
        repeat (3) @(negedge mclk_i);
    endtask
    always @(negedge mclk_i) begin
        if (wb_update_o === 1'b1) upd++;
        if (pix_valid_o === 1'b1 && exp_q.size() == 0) check("pix_extra", 8'h01, 8'h00);
        else if (pix_valid_o === 1'b1) check("pix_o", pix_o, exp_q.pop_front());
    end
    initial begin
        #700000 fails++;
        report_and_stop();
    end
    // ==========================================================
    // Scenarios
    initial begin
        r = rnd();
        {ap_threshold_i, ap_strength_i, wb_luma_lo_i, wb_luma_hi_i} = r[7:0];
        interlaced_i = r[8];
        repeat (3) @(negedge mclk_i);
        rst_b_i = 1'b1;
        repeat (5) @(negedge mclk_i);
        for (int i = 0; i < 6; i++) rdchk(8'h20 + 8'(i), rst_tab[i]);
        r = rnd();
        bright_pixel_ratio_limit = 8'h01 + r[7:0] % 8'h9A;
        lim = bright_pixel_ratio_limit * (interlaced_i ? 16'hD : 16'h7);
        host_u.reg_write(8'h24, bright_pixel_ratio_limit);
        rdchk(8'h24, bright_pixel_ratio_limit);
        host_u.reg_write(8'h21, 8'h05);
        rdchk(8'h21, 8'h00);
        offset_src_host_i = 1'b1;
        host_u.reg_write(8'h21, 8'h05);
        host_u.reg_write(8'h22, 8'h83);
        rdchk(8'h22, 8'h83);
        for (int e = 1; e >= 0; e--) begin
            offset_adj_en_i = e[0];
            for (int i = 0; i < 40; i++) begin
                r = rnd();
                ch = (r[1:0] == 2'h3) ? 2'h1 : r[1:0];
                pix(ch, (i < 4) ? {8{i[0]}} : r[15:8], (ch == 2'h0) ? 8'h05 : 8'h83);
            end
            @(negedge mclk_i) pix_valid_i = 1'b0;
        end
        offset_src_host_i = 1'b0;
        int_luma_offset_i = 8'h07;
        int_offset_valid_i = 1'b1;
        @(negedge mclk_i) int_offset_valid_i = 1'b0;
        rdchk(8'h21, 8'h07);
        host_u.reg_write(8'h20, 8'hC6);
        wb_enable_i = 1'b1;
        frame();
        for (int i = 0; i < 1024; i++) pix(2'h0, 8'hFF, 8'h00);
        @(negedge mclk_i) pix_valid_i = 1'b0;
        upd = 0;
        frame();
        check("avg", luminance_average_o, 8'h01);
        check("wb_cnt", wb_pix_count_o[11:4], 8'h40);
        check("darken", 8'(ae_darken_o), 8'(lim < 16'h3E8));
        check("stable", 8'(ae_stable_o), 8'(lim >= 16'h3E8));
        repeat (3) frame();
        check("fast_upd", 8'(upd), 8'h04);
        check("manual", 8'(wb_manual_en_o), 8'h01);
        host_u.reg_write(8'h20, 8'hC4);
        wb_stable_i = 1'b1;
        frame();
        upd = 0;
        repeat (32) frame();
        check("slow_upd", 8'(upd), 8'h02);
        check("fast", 8'(wb_fast_o), 8'h00);
        qres_one_line_i = 1'b1;
        host_u.reg_write(8'h23, 8'h13);
        rdchk(8'h23, 8'h13);
        check("ob_upd", 8'(ob_update_en_o), 8'h01);
        check("qclk", 8'(qres_clk_opt_o), 8'h01);
        host_u.reg_write(8'h23, 8'hC0);
        check("ob_upd", 8'(ob_update_en_o), 8'h00);
        report_and_stop();
    end
endmodule // itrb_image_tuning_tb
bind itrb_image_tuning itrb_image_tuning_checker chk_u (.*);
